/* File: src/dsi_top.sv */
// split-port double-rate sram interface, device side
//
// Summary of operation
// - read and write addresses share one bus and are taken on alternating rising clock edges.
// - every read and every write moves exactly two words for one address.
// - the two words move in sequence on successive rising edges of a complementary clock pair.
// - a word is 9, 18 or 36 bits wide, the same on the read and the write port.
// - with the latency pin high, read data appears one and a half cycles after the read address.
// - with the latency pin low, read data appears one cycle after the read address.
// - all inputs are captured on rising edges of the input clock pair only.
// - read data leaves from registers on the output clock pair, or the input pair in one-domain use.
// - reads and writes run independently and may be in progress together.
// - each port has its own select that enables it on its own.
// - a captured write completes internally with no further action from the controller.
// - a read returns the latest written data even before that write has completed internally.
// - the device drives a complementary echo clock pair alongside the read data.
`include "dsi_map.svh"

module dsi_top #(
    parameter int WORD_W = `DSI_WORD_W_DEF,
    parameter int ADDR_W = `DSI_ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic one_domain,
    input wire logic latency_mode_pin,
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wr_data,
    output logic [WORD_W-1:0] rd_data,
    output logic rd_valid,
    output logic echo_clk,
    output logic echo_clk_n
);

    // ---------------------------------------------------------------
    // parameter check
    // ---------------------------------------------------------------
    generate
        if (!(WORD_W == 9 || WORD_W == 18 || WORD_W == 36)) begin : g_bad_word
            $error("word width must be 9, 18 or 36");
        end
        if (ADDR_W < 1 || ADDR_W > `DSI_ADDR_MAX) begin : g_bad_addr
            $error("address width out of range");
        end
    endgenerate

    localparam int SW = `DSI_CTL_W + ADDR_W + WORD_W;
    localparam int SLOTS = `DSI_SLOTS;
    localparam int WR_HOLD = `DSI_WR_HOLD;

    // ---------------------------------------------------------------
    // pin synchronisation
    // ---------------------------------------------------------------
    // the link clocks are slow against clk, so they are sampled as
    // plain levels; data pins share the same two-flop delay so they
    // stay aligned with the clock edges that qualify them
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] sync_pins;
    dsi_pkg::dsi_pins_t pins_s;
    logic [ADDR_W-1:0] addr_s;
    logic [WORD_W-1:0] wdata_s;

    assign raw_pins = {wr_data, addr, k_clk, k_clk_n, c_clk, c_clk_n, one_domain,
                       latency_mode_pin, rd_sel_n, wr_sel_n};

    dsi_sync #(
        .W(SW)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(raw_pins),
        .q(sync_pins)
    );

    assign pins_s = dsi_pkg::dsi_pins_t'(sync_pins[`DSI_CTL_W-1:0]);
    assign addr_s = sync_pins[`DSI_CTL_W+ADDR_W-1:`DSI_CTL_W];
    assign wdata_s = sync_pins[SW-1:`DSI_CTL_W+ADDR_W];

    // ---------------------------------------------------------------
    // clock edge detection
    // ---------------------------------------------------------------
    logic [3:0] lvl_r;
    logic [3:0] lvl_nxt;
    logic out_lvl;
    logic out_lvl_n;
    logic k_rise;
    logic kn_rise;
    logic out_edge;

    always_comb begin
        // one-domain use launches read data on the input pair
        out_lvl = pins_s.one_dom ? pins_s.k : pins_s.c;
        out_lvl_n = pins_s.one_dom ? pins_s.k_n : pins_s.c_n;
        lvl_nxt = {pins_s.k, pins_s.k_n, out_lvl, out_lvl_n};
        // only rising edges are used anywhere
        k_rise = pins_s.k & ~lvl_r[3];
        kn_rise = pins_s.k_n & ~lvl_r[2];
        out_edge = (out_lvl & ~lvl_r[1]) | (out_lvl_n & ~lvl_r[0]);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lvl_r <= 4'h0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // ---------------------------------------------------------------
    // write port
    // ---------------------------------------------------------------
    logic wr0_cap;
    logic wr1_cap;
    logic wr_commit;
    logic warm_r;
    logic warm_nxt;
    logic [2:0] wait_r;
    logic [2:0] wait_nxt;
    logic [WORD_W-1:0] w0_r;
    logic [WORD_W-1:0] w0_nxt;
    dsi_pkg::dsi_wpend_t wpend_r;
    dsi_pkg::dsi_wpend_t wpend_nxt;

    always_comb begin
        // first word and the select on the rising input clock, address
        // and second word on the rising complementary clock
        wr0_cap = k_rise & ~pins_s.wr_sel_n;
        wr1_cap = kn_rise & warm_r;
        // the write waits a few clk so a read right behind it is served
        // from here; a newer write pushes it into the array early
        wr_commit = wpend_r.vld && (wait_r == 3'h0 || wr1_cap);
        warm_nxt = warm_r;
        w0_nxt = w0_r;
        wait_nxt = wait_r;
        wpend_nxt = wpend_r;
        if (wr_commit) begin
            wpend_nxt.vld = 1'h0;
        end else if (wpend_r.vld) begin
            wait_nxt = wait_r - 3'h1;
        end
        if (wr0_cap) begin
            warm_nxt = 1'h1;
            w0_nxt = wdata_s;
        end else if (wr1_cap) begin
            warm_nxt = 1'h0;
            wait_nxt = 3'(`DSI_WR_HOLD);
            wpend_nxt.vld = 1'h1;
            wpend_nxt.addr = `DSI_ADDR_MAX'(addr_s);
            wpend_nxt.w0 = `DSI_WORD_MAX'(w0_r);
            wpend_nxt.w1 = `DSI_WORD_MAX'(wdata_s);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            warm_r <= 1'h0;
            wait_r <= 3'h0;
            w0_r <= '0;
            wpend_r <= '0;
        end else begin
            warm_r <= warm_nxt;
            wait_r <= wait_nxt;
            w0_r <= w0_nxt;
            wpend_r <= wpend_nxt;
        end
    end

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [WORD_W-1:0] mem_w0;
    logic [WORD_W-1:0] mem_w1;

    dsi_mem #(
        .ADDR_W(ADDR_W),
        .WORD_W(WORD_W)
    ) u_mem (
        .clk(clk),
        .wr_en(wr_commit),
        .wr_addr(wpend_r.addr[ADDR_W-1:0]),
        .wr_w0(wpend_r.w0[WORD_W-1:0]),
        .wr_w1(wpend_r.w1[WORD_W-1:0]),
        .rd_addr(addr_s),
        .rd_w0(mem_w0),
        .rd_w1(mem_w1)
    );

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    logic rd_cap;
    logic wr_hit;
    logic [WORD_W-1:0] rd_w0;
    logic [WORD_W-1:0] rd_w1;
    logic [1:0] lat_idx;
    dsi_pkg::dsi_beat_t slot_r [SLOTS];
    dsi_pkg::dsi_beat_t slot_nxt [SLOTS];
    dsi_pkg::dsi_beat_t out_r;
    dsi_pkg::dsi_beat_t out_nxt;

    always_comb begin
        rd_cap = k_rise & ~pins_s.rd_sel_n;
        // the array still holds old data while a write is pending
        wr_hit = wpend_r.vld && (wpend_r.addr[ADDR_W-1:0] == addr_s);
        rd_w0 = wr_hit ? wpend_r.w0[WORD_W-1:0] : mem_w0;
        rd_w1 = wr_hit ? wpend_r.w1[WORD_W-1:0] : mem_w1;
        // first word lands after lat half cycles, so it is loaded one
        // slot short of that
        lat_idx = pins_s.lat_mode ? 2'(`DSI_LAT_HI_HALF - 1) : 2'(`DSI_LAT_LO_HALF - 1);
        out_nxt = out_r;
        for (int i = 0; i < SLOTS; i++) begin
            slot_nxt[i] = slot_r[i];
        end
        if (out_edge) begin
            out_nxt = slot_r[0];
            for (int i = 0; i < SLOTS - 1; i++) begin
                slot_nxt[i] = slot_r[i+1];
            end
            slot_nxt[SLOTS-1] = '0;
        end
        // writes never touch the slots, so both ports run side by side
        if (rd_cap) begin
            slot_nxt[lat_idx].vld = 1'h1;
            slot_nxt[lat_idx].word = `DSI_WORD_MAX'(rd_w0);
            slot_nxt[lat_idx+2'h1].vld = 1'h1;
            slot_nxt[lat_idx+2'h1].word = `DSI_WORD_MAX'(rd_w1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_r[i] <= '0;
            end
            out_r <= '0;
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_r[i] <= slot_nxt[i];
            end
            out_r <= out_nxt;
        end
    end

    assign rd_data = out_r.word[WORD_W-1:0];
    assign rd_valid = out_r.vld;

    // ---------------------------------------------------------------
    // echo clocks
    // ---------------------------------------------------------------
    // echoes copy the launching pair one clk late, the same delay as
    // the data registers, so the controller sees them aligned
    logic [1:0] echo_r;
    logic [1:0] echo_nxt;

    always_comb begin
        echo_nxt = {out_lvl, out_lvl_n};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            echo_r <= 2'h0;
        end else begin
            echo_r <= echo_nxt;
        end
    end

    assign echo_clk = echo_r[1];
    assign echo_clk_n = echo_r[0];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_lat_slow_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_cap && pins_s.lat_mode && !out_edge |=> slot_r[2].vld && slot_r[3].vld &&
            slot_r[2].word[WORD_W-1:0] == $past(rd_w0))
        else $error("slow latency read not loaded at half cycle three");

    chk_lat_fast_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_cap && !pins_s.lat_mode && !out_edge && !slot_r[2].vld |=> slot_r[1].vld && slot_r[2].vld)
        else $error("fast latency read not loaded at half cycle two");

    chk_out_launch: assert property (
        @(posedge clk) disable iff (sys_rst)
        out_edge |=> rd_valid == $past(slot_r[0].vld) && rd_data == $past(slot_r[0].word[WORD_W-1:0]))
        else $error("read beat not launched on output clock edge");

    chk_out_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        !out_edge |=> $stable(rd_data) && $stable(rd_valid))
        else $error("read output changed without an output clock edge");

    chk_wr_commit: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(wpend_r.vld) |-> ##[0:WR_HOLD] wr_commit)
        else $error("pending write not committed within its hold time");

    chk_wr_pair: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(wpend_r.vld) |-> $past(warm_r) && $past(kn_rise) && !warm_r)
        else $error("write committed without both words");

    chk_coherent_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_cap && wr_hit |-> rd_w0 == wpend_r.w0[WORD_W-1:0] && rd_w1 == wpend_r.w1[WORD_W-1:0])
        else $error("read missed a pending write to the same address");

    chk_echo_follow: assert property (
        @(posedge clk) disable iff (sys_rst)
        ##1 echo_clk == $past(out_lvl) && echo_clk_n == $past(out_lvl_n))
        else $error("echo clocks do not follow the output pair");

    chk_addr_turns: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr1_cap |-> !rd_cap && !k_rise)
        else $error("write address taken on the read address edge");

endmodule

/* File: src/dsi_map.svh */
// constants of the split-port double-rate sram interface
`ifndef DSI_MAP_SVH
`define DSI_MAP_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define DSI_WORD_W_DEF 36
`define DSI_ADDR_W_DEF 20
`define DSI_WORD_MAX 36
`define DSI_ADDR_MAX 22

// ---------------------------------------------------------------
// read latency, counted in output clock half cycles
// ---------------------------------------------------------------
`define DSI_LAT_HI_HALF 3
`define DSI_LAT_LO_HALF 2
`define DSI_SLOTS 4

// ---------------------------------------------------------------
// self-timed write, clk cycles a captured write waits before commit
// ---------------------------------------------------------------
`define DSI_WR_HOLD 4

// ---------------------------------------------------------------
// pin synchroniser
// ---------------------------------------------------------------
`define DSI_CTL_W 8
`define DSI_SYNC_RST 1'h0

`endif

/* File: src/dsi_pkg.sv */
// types of the split-port double-rate sram interface
`include "dsi_map.svh"

package dsi_pkg;

    // control pins after the synchroniser, msb first
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic one_dom;
        logic lat_mode;
        logic rd_sel_n;
        logic wr_sel_n;
    } dsi_pins_t;

    // one read beat waiting for, or sitting on, the output pins
    typedef struct packed {
        logic vld;
        logic [`DSI_WORD_MAX-1:0] word;
    } dsi_beat_t;

    // a captured write waiting for its self-timed commit
    typedef struct packed {
        logic vld;
        logic [`DSI_ADDR_MAX-1:0] addr;
        logic [`DSI_WORD_MAX-1:0] w0;
        logic [`DSI_WORD_MAX-1:0] w1;
    } dsi_wpend_t;

endpackage

/* File: src/dsi_sync.sv */
// two-flop synchroniser for every pin that enters the clk domain
`include "dsi_map.svh"

module dsi_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ---------------------------------------------------------------
    // one pair of flops per bit
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_r;
            logic meta_nxt;
            logic hold_r;
            logic hold_nxt;
            always_comb begin
                meta_nxt = d[gi];
                hold_nxt = meta_r;
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    meta_r <= `DSI_SYNC_RST;
                    hold_r <= `DSI_SYNC_RST;
                end else begin
                    meta_r <= meta_nxt;
                    hold_r <= hold_nxt;
                end
            end
            assign q[gi] = hold_r;
        end
    endgenerate

endmodule

/* File: src/dsi_mem.sv */
// storage array, two words per address
module dsi_mem #(
    parameter int ADDR_W = 20,
    parameter int WORD_W = 36
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_w0,
    input wire logic [WORD_W-1:0] wr_w1,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_w0,
    output logic [WORD_W-1:0] rd_w1
);

    // ---------------------------------------------------------------
    // array
    // ---------------------------------------------------------------
    // both words of a location are stored side by side so one write
    // commits the whole pair at once
    logic [2*WORD_W-1:0] cell_r [2**ADDR_W];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            cell_r[wr_addr] <= {wr_w1, wr_w0};
        end
    end

    always_comb begin
        rd_w0 = cell_r[rd_addr][WORD_W-1:0];
        rd_w1 = cell_r[rd_addr][2*WORD_W-1:WORD_W];
    end

endmodule

/* File: verification/dsi_ctrl_model.sv */
// memory-controller model: link clocks, shared address, write data and port selects
module dsi_ctrl_model #(
    parameter int ADDR_W = 4,
    parameter int WORD_W = 18
) (
    input wire logic clk,
    input wire logic run,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] rd_addr_req,
    input wire logic [ADDR_W-1:0] wr_addr_req,
    input wire logic [WORD_W-1:0] w0_req,
    input wire logic [WORD_W-1:0] w1_req,
    output logic req_ack,
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic rd_sel_n,
    output logic wr_sel_n,
    output logic [ADDR_W-1:0] addr,
    output logic [WORD_W-1:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] phase;
    logic wr_hold;
    logic [ADDR_W-1:0] waddr_hold;
    logic [WORD_W-1:0] w1_hold;

    // one link cycle is eight system clocks; requests are taken at phase 6
    assign req_ack = run && phase == 3'h6;

    initial begin
        phase = 3'h0;
        {k_clk, k_clk_n, c_clk, c_clk_n} = 4'h0;
        {rd_sel_n, wr_sel_n} = 2'h3;
        addr = '0;
        wr_data = '0;
        wr_hold = 1'b0;
        waddr_hold = '0;
        w1_hold = '0;
    end

    always @(posedge clk) begin
        if (!run) begin
            // clocks stand still between frames; released lines keep toggling
            phase <= 3'h0;
            {k_clk, k_clk_n, c_clk, c_clk_n} <= 4'h0;
            {rd_sel_n, wr_sel_n} <= 2'h3;
            addr <= ~addr;
            wr_data <= ~wr_data;
        end else begin
            phase <= phase + 3'h1;
            case (phase)
                3'h0: begin
                    k_clk <= 1'b1;
                    k_clk_n <= 1'b0;
                end
                3'h2: begin
                    c_clk <= 1'b1;
                    c_clk_n <= 1'b0;
                    addr <= wr_hold ? waddr_hold : ADDR_W'($urandom);
                    wr_data <= wr_hold ? w1_hold : WORD_W'($urandom);
                end
                3'h4: begin
                    k_clk <= 1'b0;
                    k_clk_n <= 1'b1;
                end
                3'h6: begin
                    c_clk <= 1'b0;
                    c_clk_n <= 1'b1;
                    rd_sel_n <= !rd_req;
                    wr_sel_n <= !wr_req;
                    addr <= rd_req ? rd_addr_req : ADDR_W'($urandom);
                    wr_data <= wr_req ? w0_req : WORD_W'($urandom);
                    wr_hold <= wr_req;
                    waddr_hold <= wr_addr_req;
                    w1_hold <= w1_req;
                end
                default: begin
                end
            endcase
        end
    end
endmodule

/* File: verification/tb_ddr_split_port_sram_interface.sv */
// self-checking bench for the split-port double-rate sram interface
`include "dsi_map.svh"

module tb_ddr_split_port_sram_interface;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int ADDR_W = 4;
    localparam int WORD_W = 18;

    typedef struct packed {
        logic [31:0] edge_idx;
        logic [WORD_W-1:0] word;
    } dsi_exp_t;

    logic clk, sys_rst, one_domain, latency_mode_pin, run;
    logic rd_req, wr_req, req_ack;
    logic [ADDR_W-1:0] rd_addr_req, wr_addr_req, addr;
    logic [WORD_W-1:0] w0_req, w1_req, wr_data, rd_data;
    logic k_clk, k_clk_n, c_clk, c_clk_n, rd_sel_n, wr_sel_n;
    logic rd_valid, echo_clk, echo_clk_n, echo_q, echo_n_q, beat_due;
    logic [2*WORD_W-1:0] mem_model [2**ADDR_W];
    dsi_exp_t exp_q[$];
    int fail_count, cmp_count, edge_cnt, cyc_cnt;

    dsi_top #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .one_domain(one_domain),
        .latency_mode_pin(latency_mode_pin), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .echo_clk(echo_clk), .echo_clk_n(echo_clk_n));

    dsi_ctrl_model #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) ctrl_u (
        .clk(clk), .run(run), .rd_req(rd_req), .wr_req(wr_req),
        .rd_addr_req(rd_addr_req), .wr_addr_req(wr_addr_req), .w0_req(w0_req),
        .w1_req(w1_req), .req_ack(req_ack), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .c_clk(c_clk), .c_clk_n(c_clk_n), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n),
        .addr(addr), .wr_data(wr_data));

    always #50 clk = ~clk;

    // ---------------------------------------------------------------
    // compare and closing tasks
    // ---------------------------------------------------------------
    task automatic chk_beat(input logic gv, input logic [WORD_W-1:0] gd, input logic ev,
                            input logic [WORD_W-1:0] ed);
        cmp_count++;
        if (gv !== ev || (ev && gd !== ed)) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h_%h exp=%h_%h", $time, gv, gd, ev, ed);
        end
    endtask

    task automatic chk_count(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // result watcher: one look per output-clock edge seen on the echo pair
    // ---------------------------------------------------------------
    always @(negedge clk) begin
        if (sys_rst) begin
            edge_cnt = 0;
            beat_due = 1'b0;
        end else if (beat_due) begin
            beat_due = 1'b0;
            if (exp_q.size() > 0 && exp_q[0].edge_idx == edge_cnt) begin
                chk_beat(rd_valid, rd_data, 1'b1, exp_q[0].word);
                void'(exp_q.pop_front());
            end else begin
                chk_beat(rd_valid, rd_data, 1'b0, '0);
            end
            edge_cnt++;
        end
        // both echo phases count, so a lost or stuck echo shifts every later beat
        if (!sys_rst && ((echo_clk === 1'b1 && echo_q === 1'b0) || (echo_clk_n === 1'b1 && echo_n_q === 1'b0)))
            beat_due = 1'b1;
        echo_q = echo_clk;
        echo_n_q = echo_clk_n;
    end

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 6000) begin
            fail_count++;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // traffic in one latency and clock-domain mode
    // ---------------------------------------------------------------
    task automatic run_mode(input logic od, input logic lat, input int ncyc, input int nfill);
        int t;
        int lat_h;
        logic rd, wr;
        logic [ADDR_W-1:0] ra, wa, last_wa;
        logic [WORD_W-1:0] w0, w1;
        last_wa = '0;
        sys_rst <= 1'b1;
        run <= 1'b0;
        one_domain <= od;
        latency_mode_pin <= lat;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        lat_h = lat ? `DSI_LAT_HI_HALF : `DSI_LAT_LO_HALF;
        run <= 1'b1;
        for (t = 0; t < ncyc; t++) begin
            rd = t >= nfill && $urandom_range(0, 2) != 0;
            wr = t < nfill || $urandom_range(0, 2) != 0;
            wa = t < nfill ? ADDR_W'(t) : ADDR_W'($urandom);
            ra = $urandom_range(0, 1) ? last_wa : ADDR_W'($urandom);
            // same-cycle read and write of one address is left undefined
            if (rd && wr && ra == wa)
                ra = ra ^ 1;
            w0 = WORD_W'($urandom);
            w1 = WORD_W'($urandom);
            if (rd) begin
                exp_q.push_back({32'(2 * (t + 1) + lat_h - (od ? 0 : 1)), mem_model[ra][WORD_W-1:0]});
                exp_q.push_back({32'(2 * (t + 1) + lat_h - (od ? 0 : 1) + 1), mem_model[ra][2*WORD_W-1:WORD_W]});
            end
            if (wr) begin
                mem_model[wa] = {w1, w0};
                last_wa = wa;
            end
            rd_req <= rd;
            wr_req <= wr;
            rd_addr_req <= ra;
            wr_addr_req <= wa;
            w0_req <= w0;
            w1_req <= w1;
            @(posedge clk iff req_ack);
        end
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        repeat (48) @(posedge clk);
        chk_count(exp_q.size(), 0);
        run <= 1'b0;
    endtask

    initial begin
        int m;
        clk = 1'b0;
        sys_rst = 1'b1;
        one_domain = 1'b1;
        latency_mode_pin = 1'b0;
        run = 1'b0;
        {rd_req, wr_req} = 2'h0;
        {rd_addr_req, wr_addr_req} = '0;
        {w0_req, w1_req} = '0;
        {echo_q, echo_n_q, beat_due} = 3'h0;
        {fail_count, cmp_count, edge_cnt, cyc_cnt} = '0;
        void'($urandom(32'h3f4fd7ee));
        for (m = 0; m < 4; m++)
            run_mode(m[1], m[0], m == 0 ? 40 : 24, m == 0 ? 16 : 0);
        stop_test();
    end
endmodule
